/* File: core/mmdcfg_regs.sv */
// MMD indirect configuration register bank behind the two portal registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Post-increment read returns then advances address
// - Operation field picks register or data modes
// - Low FLP code selects 8 or 16 ms
// - High FLP code selects 8 or 16 ms
// - Link-up time field, reset binary 100
// - Override bit selects LED style
// - Override bit always reads zero
// - Status bit takes written override value
// - Status bit starts from strap pin
module mmdcfg_regs
    import mmdcfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    input wire logic ledStyleStrap,
    output logic ledStyleSelect,
    output logic [1:0] flpInterval,
    output logic [2:0] linkUpTime
);
    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta; // First stage
    logic rstSync; // Released reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] ctrl, next_ctrl; // Access control portal
    logic [15:0] mmdAddr, next_mmdAddr; // Indirect register address
    logic [15:0] flpLo, next_flpLo; // FLP timing low
    logic [15:0] flpHi, next_flpHi; // FLP timing high
    logic [8:0] linkUp, next_linkUp; // Link-up time register bits 8:0
    logic [15:0] cmnCtrl, next_cmnCtrl; // Common control RW bits
    logic ledStat, next_ledStat; // LED style status
    logic strapTaken, next_strapTaken; // Strap captured after release
    logic [15:0] rdata, next_rdata; // Registered read data

    // Indirect read mux
    function automatic logic [15:0] mmdRead(input logic [4:0] dev, input logic [15:0] ra,
            input logic [15:0] lo, input logic [15:0] hi, input logic [8:0] lu,
            input logic [15:0] cc, input logic st);
        logic [15:0] v;
        v = 16'h0000;
        if (dev == DEV_AN && ra == FLP_LO_ADDR) begin
            v = lo;
        end else if (dev == DEV_AN && ra == FLP_HI_ADDR) begin
            v = hi;
        end else if (dev == DEV_PMA && ra == LINKUP_ADDR) begin
            v = {7'h00, lu};
        end else if (dev == DEV_CMN && ra == CMN_CTRL_ADDR) begin
            v = cc;
            v[LED_OVR_BIT] = 1'b0;
            v[LED_STAT_BIT] = st;
        end
        return v;
    endfunction

    logic [1:0] op; // Operation mode
    logic [4:0] dev; // Selected device
    assign op = ctrl[OP_HI:OP_LO];
    assign dev = ctrl[DEVAD_HI:0];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_mmdAddr = mmdAddr;
        next_flpLo = flpLo;
        next_flpHi = flpHi;
        next_linkUp = linkUp;
        next_cmnCtrl = cmnCtrl;
        next_ledStat = ledStat;
        next_strapTaken = 1'b1;
        next_rdata = rdata;
        // Strap sampled on the first clock after release
        if (!strapTaken) begin
            next_ledStat = ledStyleStrap;
        end
        if (regWrite && regAddr == PORTAL_CTRL) begin
            next_ctrl = regWdata;
        end else if (regWrite && regAddr == PORTAL_DATA) begin
            if (op == OP_REG) begin
                next_mmdAddr = regWdata;
            end else begin
                // Data write to the addressed register
                if (dev == DEV_AN && mmdAddr == FLP_LO_ADDR) begin
                    next_flpLo = regWdata;
                end else if (dev == DEV_AN && mmdAddr == FLP_HI_ADDR) begin
                    next_flpHi = regWdata;
                end else if (dev == DEV_PMA && mmdAddr == LINKUP_ADDR) begin
                    next_linkUp = regWdata[8:0];
                end else if (dev == DEV_CMN && mmdAddr == CMN_CTRL_ADDR) begin
                    next_cmnCtrl = regWdata;
                    next_cmnCtrl[LED_OVR_BIT] = 1'b0;
                    next_cmnCtrl[LED_STAT_BIT] = 1'b0;
                    next_ledStat = regWdata[LED_OVR_BIT];
                end
                if (op == OP_DATA_INC_RW || op == OP_DATA_INC_W) begin
                    next_mmdAddr = mmdAddr + 16'h0001;
                end
            end
        end else if (regRead && regAddr == PORTAL_CTRL) begin
            next_rdata = ctrl;
        end else if (regRead && regAddr == PORTAL_DATA) begin
            if (op == OP_REG) begin
                next_rdata = mmdAddr;
            end else begin
                next_rdata = mmdRead(dev, mmdAddr, flpLo, flpHi, linkUp, cmnCtrl, ledStat);
                if (op == OP_DATA_INC_RW) begin
                    next_mmdAddr = mmdAddr + 16'h0001;
                end
            end
        end else if (regRead) begin
            // Other clause-22 numbers belong elsewhere
            next_rdata = 16'h0000;
        end
    end

    // Register update
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            ctrl <= CTRL_RST;
            mmdAddr <= DATA_RST;
            flpLo <= FLP_LO_RST;
            flpHi <= FLP_HI_RST;
            linkUp <= LINKUP_RST;
            cmnCtrl <= 16'h0000;
            ledStat <= 1'b0;
            strapTaken <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            ctrl <= next_ctrl;
            mmdAddr <= next_mmdAddr;
            flpLo <= next_flpLo;
            flpHi <= next_flpHi;
            linkUp <= next_linkUp;
            cmnCtrl <= next_cmnCtrl;
            ledStat <= next_ledStat;
            strapTaken <= next_strapTaken;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdata = rdata;
    assign ledStyleSelect = ledStat;
    assign linkUpTime = linkUp[3:1];

    // Interval decode
    mmdcfg_flp_decode uDecode (
        .flpLo(flpLo),
        .flpHi(flpHi),
        .interval(flpInterval)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic dataRd; // Data-mode portal read
    assign dataRd = regRead && !regWrite && regAddr == PORTAL_DATA && op != OP_REG;

    property p_incRead;
        @(posedge core_clk) disable iff (!rstSync)
        dataRd && op == OP_DATA_INC_RW |=> mmdAddr == $past(mmdAddr) + 16'h0001;
    endproperty
    a_incRead: assert property (p_incRead) else $error("address not advanced");

    property p_noIncRead;
        @(posedge core_clk) disable iff (!rstSync)
        dataRd && op != OP_DATA_INC_RW |=> $stable(mmdAddr);
    endproperty
    a_noIncRead: assert property (p_noIncRead) else $error("address moved on read");

    property p_flpReset;
        @(posedge core_clk) $rose(rstSync) |-> flpLo == FLP_LO_RST && flpHi == FLP_HI_RST
            && flpInterval == IVL_8MS;
    endproperty
    a_flpReset: assert property (p_flpReset) else $error("bad FLP reset");

    property p_flp16;
        @(posedge core_clk) disable iff (!rstSync)
        flpLo == FLP_LO_16MS && flpHi == FLP_HI_16MS |-> flpInterval == IVL_16MS;
    endproperty
    a_flp16: assert property (p_flp16) else $error("16 ms not decoded");

    property p_linkReset;
        @(posedge core_clk) $rose(rstSync) |-> linkUpTime == LINKUP_RST[3:1]
            && linkUp == LINKUP_RST;
    endproperty
    a_linkReset: assert property (p_linkReset) else $error("bad link-up reset");

    property p_ovrReadZero;
        @(posedge core_clk) disable iff (!rstSync)
        dataRd && dev == DEV_CMN && mmdAddr == CMN_CTRL_ADDR |=> regRdata[LED_OVR_BIT] == 1'b0;
    endproperty
    a_ovrReadZero: assert property (p_ovrReadZero) else $error("override read nonzero");

    property p_ovrStatus;
        @(posedge core_clk) disable iff (!rstSync)
        regWrite && regAddr == PORTAL_DATA && op != OP_REG && dev == DEV_CMN
            && mmdAddr == CMN_CTRL_ADDR |=> ledStyleSelect == $past(regWdata[LED_OVR_BIT]);
    endproperty
    a_ovrStatus: assert property (p_ovrStatus) else $error("status not updated");

    property p_strap;
        @(posedge core_clk) disable iff (!rstSync)
        !strapTaken |=> ledStyleSelect == $past(ledStyleStrap);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not taken");

    c_incRead: cover property (@(posedge core_clk) disable iff (!rstSync)
        dataRd && op == OP_DATA_INC_RW ##2 dataRd ##2 dataRd);
    c_flp16: cover property (@(posedge core_clk) disable iff (!rstSync)
        flpInterval == IVL_16MS);
    c_ovr: cover property (@(posedge core_clk) disable iff (!rstSync) $changed(ledStyleSelect));
endmodule
`default_nettype wire

/* File: core/mmdcfg_pkg.sv */
// Package: portal register constants, MMD layout and reset values
package mmdcfg_pkg;
    // Clause-22 portal register numbers
    localparam logic [4:0] PORTAL_CTRL = 5'h0D;
    localparam logic [4:0] PORTAL_DATA = 5'h0E;
    // Operation field of the access control portal
    localparam int OP_HI = 15;
    localparam int OP_LO = 14;
    localparam logic [1:0] OP_REG = 2'h0;
    localparam logic [1:0] OP_DATA = 2'h1;
    localparam logic [1:0] OP_DATA_INC_RW = 2'h2;
    localparam logic [1:0] OP_DATA_INC_W = 2'h3;
    // Device address field, bits 4:0
    localparam int DEVAD_HI = 4;
    // MMD device numbers
    localparam logic [4:0] DEV_AN = 5'h00;
    localparam logic [4:0] DEV_PMA = 5'h01;
    localparam logic [4:0] DEV_CMN = 5'h02;
    // MMD register numbers
    localparam logic [15:0] FLP_LO_ADDR = 16'h0003;
    localparam logic [15:0] FLP_HI_ADDR = 16'h0004;
    localparam logic [15:0] LINKUP_ADDR = 16'h005A;
    localparam logic [15:0] CMN_CTRL_ADDR = 16'h0000;
    // Reset values
    localparam logic [15:0] FLP_LO_RST = 16'h4000;
    localparam logic [15:0] FLP_HI_RST = 16'h0003;
    localparam logic [8:0] LINKUP_RST = 9'h108;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // Burst interval codes
    localparam logic [15:0] FLP_LO_8MS = 16'h4000;
    localparam logic [15:0] FLP_LO_16MS = 16'h1A80;
    localparam logic [15:0] FLP_HI_8MS = 16'h0003;
    localparam logic [15:0] FLP_HI_16MS = 16'h0006;
    // Common control field positions
    localparam int LED_OVR_BIT = 4;
    localparam int LED_STAT_BIT = 3;
    // Interval selection encoding
    localparam logic [1:0] IVL_8MS = 2'h0;
    localparam logic [1:0] IVL_16MS = 2'h1;
    localparam logic [1:0] IVL_RSVD = 2'h2;
endpackage

/* File: core/mmdcfg_flp_decode.sv */
// FLP burst timing code decoder
`timescale 1ns/1ps
`default_nettype none
module mmdcfg_flp_decode
    import mmdcfg_pkg::*;
(
    input wire logic [15:0] flpLo,
    input wire logic [15:0] flpHi,
    output logic [1:0] interval
);
    // Decode of paired timing registers
    always_comb begin
        if (flpLo == FLP_LO_8MS && flpHi == FLP_HI_8MS) begin
            interval = IVL_8MS;
        end else if (flpLo == FLP_LO_16MS && flpHi == FLP_HI_16MS) begin
            interval = IVL_16MS;
        end else begin
            // Reserved or mixed codes
            interval = IVL_RSVD;
        end
    end
endmodule
`default_nettype wire

/* File: test/mmdcfg_host_model.sv */
// Management host model driving the clause-22 portal strobes
`timescale 1ns/1ps
`default_nettype none
module mmdcfg_host_model (
    input wire logic core_clk,
    output logic regWrite,
    output logic regRead,
    output logic [4:0] regAddr,
    output logic [15:0] regWdata,
    input wire logic [15:0] regRdata
);
    import mmdcfg_pkg::*;
    // Idle bus at time zero
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 5'h00;
        regWdata = 16'h0000;
    end
    // One write strobe; data inverted once released
    task automatic wr(input logic [4:0] a, input logic [15:0] x);
        @(negedge core_clk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = x;
        @(negedge core_clk);
        regWrite = 1'b0;
        regWdata = ~x;
    endtask
    // One read strobe; data taken after the answering edge
    task automatic rd(input logic [4:0] a, output logic [15:0] x);
        @(negedge core_clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge core_clk);
        regRead = 1'b0;
        x = regRdata;
    endtask
    // Select device and register, then a data mode
    task automatic point(input logic [4:0] dev, input logic [15:0] ra, input logic [1:0] op);
        wr(PORTAL_CTRL, {11'h000, dev});
        wr(PORTAL_DATA, ra);
        wr(PORTAL_CTRL, {op, 9'h000, dev});
    endtask
endmodule
`default_nettype wire

/* File: test/mmdcfg_regs_tb_top.sv */
// Self-checking bench for the portal register bank
`timescale 1ns/1ps
`default_nettype none
module mmdcfg_regs_tb_top;
    import mmdcfg_pkg::*;
    logic core_clk, rstn, ledStyleStrap, regWrite, regRead, ledStyleSelect;
    logic [4:0] regAddr;
    logic [15:0] regWdata, regRdata, d;
    logic [1:0] flpInterval;
    logic [2:0] linkUpTime;
    logic [31:0] lfsr = 32'hBF70AEF8;
    int mem[int];
    logic [15:0] mCtrl, mAddr;
    logic mStat;
    logic [15:0] expQ[$];
    int fails = 0;
    int checkCount = 0;
    localparam int KLU = 65536 * int'(DEV_PMA) + int'(LINKUP_ADDR);
    localparam int KCC = 65536 * int'(DEV_CMN) + int'(CMN_CTRL_ADDR);
    mmdcfg_regs u_dut (.core_clk(core_clk), .rstn(rstn), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .ledStyleStrap(ledStyleStrap), .ledStyleSelect(ledStyleSelect),
        .flpInterval(flpInterval), .linkUpTime(linkUpTime));
    mmdcfg_host_model u_host (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    // Reference behaviour of one portal access
    function automatic logic [15:0] acc(logic w, logic [4:0] a, logic [15:0] x);
        int k;
        logic [15:0] r;
        k = int'(mCtrl[4:0]) * 65536 + int'(mAddr);
        r = 16'h0000;
        if (a == PORTAL_CTRL) begin
            r = mCtrl;
            if (w) mCtrl = x;
        end else if (a == PORTAL_DATA && mCtrl[15:14] == OP_REG) begin
            r = mAddr;
            if (w) mAddr = x;
        end else if (a == PORTAL_DATA) begin
            if (mem.exists(k)) r = mem[k][15:0] | (k == KCC ? {12'h000, mStat, 3'h0} : 16'h0000);
            if (w && k == KCC) mStat = x[4];
            if (w && mem.exists(k)) mem[k] = x & (k == KCC ? 16'hFFE7 : k == KLU ? 16'h01FF : 16'hFFFF);
            if (mCtrl[15:14] == OP_DATA_INC_RW || (w && mCtrl[15:14] == OP_DATA_INC_W)) mAddr++;
        end
        return r;
    endfunction
    // Model follows every strobe the design takes
    always @(posedge core_clk) begin
        if (rstn && regWrite) void'(acc(1'b1, regAddr, regWdata));
        else if (rstn && regRead) expQ.push_back(acc(1'b0, regAddr, 16'h0000));
    end
    function automatic logic [1:0] ivl();
        if (mem[3] == FLP_LO_8MS && mem[4] == FLP_HI_8MS) return IVL_8MS;
        if (mem[3] == FLP_LO_16MS && mem[4] == FLP_HI_16MS) return IVL_16MS;
        return IVL_RSVD;
    endfunction
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checkCount++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic pins();
        chk("ledStyleSelect", {15'h0000, mStat}, {15'h0000, ledStyleSelect});
        chk("linkUpTime", {13'h0000, mem[KLU][3:1]}, {13'h0000, linkUpTime});
        chk("flpInterval", {14'h0000, ivl()}, {14'h0000, flpInterval});
    endtask
    task automatic rdc(input logic [4:0] a);
        u_host.rd(a, d);
        chk("readData", expQ.pop_front(), d);
    endtask
    // Reset with a given strap level, model back to reset values
    task automatic doReset(input logic s);
        @(negedge core_clk);
        rstn = 1'b0;
        ledStyleStrap = s;
        mem.delete();
        mem[3] = FLP_LO_RST;
        mem[4] = FLP_HI_RST;
        mem[KLU] = LINKUP_RST;
        mem[KCC] = 0;
        mCtrl = CTRL_RST;
        mAddr = DATA_RST;
        mStat = s;
        expQ.delete();
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        ledStyleStrap = 1'b0;
        for (int s = 0; s < 2; s++) begin
            doReset(s[0]);
            pins();
            ledStyleStrap = ~ledStyleStrap;
            u_host.point(DEV_AN, FLP_LO_ADDR, OP_DATA_INC_RW);
            repeat (3) rdc(PORTAL_DATA);
            u_host.wr(PORTAL_CTRL, {11'h000, DEV_AN});
            rdc(PORTAL_DATA);
            rdc(PORTAL_CTRL);
            u_host.point(DEV_PMA, LINKUP_ADDR, OP_DATA);
            repeat (2) rdc(PORTAL_DATA);
            $display("reset and increment test done");
            u_host.point(DEV_AN, FLP_LO_ADDR, OP_DATA_INC_W);
            rdc(PORTAL_DATA);
            u_host.wr(PORTAL_DATA, FLP_LO_16MS);
            u_host.wr(PORTAL_DATA, FLP_HI_16MS);
            rdc(PORTAL_DATA);
            pins();
            u_host.point(DEV_AN, FLP_LO_ADDR, OP_DATA_INC_RW);
            repeat (2) rdc(PORTAL_DATA);
            u_host.point(DEV_AN, FLP_LO_ADDR, OP_DATA_INC_W);
            u_host.wr(PORTAL_DATA, FLP_LO_8MS);
            u_host.wr(PORTAL_DATA, FLP_HI_8MS);
            pins();
            u_host.point(DEV_AN, FLP_HI_ADDR, OP_DATA);
            u_host.wr(PORTAL_DATA, rnd());
            pins();
            $display("burst timing test done");
            u_host.point(DEV_PMA, LINKUP_ADDR, OP_DATA);
            rdc(PORTAL_DATA);
            for (int i = 0; i < 4; i++) begin
                u_host.wr(PORTAL_DATA, rnd() & 16'h01FF);
                rdc(PORTAL_DATA);
                pins();
            end
            u_host.point(DEV_CMN, CMN_CTRL_ADDR, OP_DATA);
            for (int i = 0; i < 6; i++) begin
                rdc(PORTAL_DATA);
                u_host.wr(PORTAL_DATA, rnd() & 16'hFFEF | {11'h000, i[0], 4'h0});
                pins();
            end
            rdc(5'h01);
            u_host.wr(PORTAL_CTRL, rnd());
            rdc(PORTAL_CTRL);
            rdc(PORTAL_DATA);
            $display("link-up, LED style and portal test done");
        end
        giveVerdict();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        $display("BAD watchdog expected done seen hang");
        giveVerdict();
    end
endmodule
`default_nettype wire
